// ===== core/rcod_pkg.sv
// types shared by the clock output block
package rcod_pkg;

	typedef struct packed {
		logic       extend;
		logic       floatSel;
		logic       slewLimit;
		logic       driveHigh;
		logic       enable;
		logic [2:0] div;
	} rcod_ctrl_s;

	typedef struct packed {
		logic clkOut;
		logic outEnable;
		logic inEnable;
		logic slewLimit;
		logic driveHigh;
	} rcod_pad_s;

	typedef enum logic [1:0] {
		RCOD_IDLE,
		RCOD_RUN,
		RCOD_DRAIN
	} rcod_state_e;

endpackage

// ===== core/rcod_regs.svh
// register offsets, field positions, reset values and timing counts of the clock output block
`ifndef RCOD_REGS_SVH
`define RCOD_REGS_SVH

`define RCOD_CTRL_OFFSET     8'h3c
`define RCOD_CTRL_RESET      8'h88

`define RCOD_BIT_EXTEND      7
`define RCOD_BIT_FLOAT       6
`define RCOD_BIT_SLEW        5
`define RCOD_BIT_DRIVE       4
`define RCOD_BIT_ENABLE      3
`define RCOD_DIV_MSB         2
`define RCOD_DIV_LSB         0

`define RCOD_MCLK_HZ         100000000
`define RCOD_SRC_HZ          32000000
`define RCOD_DRAIN_CYCLES    128

// half periods counted in ticks of twice the source rate
`define RCOD_HALF_DIV0       10'd1
`define RCOD_HALF_DIV1       10'd2
`define RCOD_HALF_DIV2       10'd4
`define RCOD_HALF_DIV3       10'd8
`define RCOD_HALF_DIV4       10'd32
`define RCOD_HALF_DIV5       10'd128
`define RCOD_HALF_DIV6       10'd512
`define RCOD_HALF_DIV7       10'd976

`endif

// ===== core/rcod_tick_gen.sv
// phase accumulator giving one-cycle ticks at an average rate below the main clock
`timescale 1ns/1ps
`include "rcod_regs.svh"
module rcod_tick_gen
	import rcod_pkg::*;
#(
	parameter int unsigned MCLK_HZ = `RCOD_MCLK_HZ,
	parameter int unsigned TICK_HZ = 2 * `RCOD_SRC_HZ
) (
	input  wire logic mclk,
	input  wire logic rst_n,
	output logic      tick
);

	localparam logic [32:0] MODULUS = 33'(MCLK_HZ);
	localparam logic [32:0] STEP    = 33'(TICK_HZ);

	logic [32:0] acc_reg;
	logic [32:0] sum;

	// tick rate must stay at or below the main clock rate
	assign sum = acc_reg + STEP;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			acc_reg <= 33'h0;
			tick    <= 1'b0;
		end else if (sum >= MODULUS) begin
			acc_reg <= sum - MODULUS;
			tick    <= 1'b1;
		end else begin
			acc_reg <= sum;
			tick    <= 1'b0;
		end
	end

endmodule

// ===== core/rcod_top.sv
// reference clock output divider with its control register and pad controls
`timescale 1ns/1ps
`include "rcod_regs.svh"

// Function
// - With output enabled, divide codes 000..110 give 32, 16, 8, 4, 1 MHz, 250 and 62.5 kHz.
// - Divide code 111 gives the source clock divided by 976, about 32.787 kHz.
// - While enable is 1 the pad carries the clock chosen by the divide field.
// - While the clock is stopped (enable 0 and any run-on over) and float select is 0 the pad is held low.
// - With extend at 0 the clock runs 128 more output cycles after enable clears.
// - With extend at 1 clearing enable stops the clock at once.
// - Float select at 1 turns off both the output and input buffers of the pad.
// - Float select at 0 turns on the output buffer and keeps the input buffer off.
// - The slew bit turns pad slew rate limiting on when 1 and off when 0.
// - The drive bit selects high pad drive when 1 and normal drive when 0.
module rcod_top
	import rcod_pkg::*;
#(
	parameter int unsigned MCLK_HZ      = `RCOD_MCLK_HZ,
	parameter int unsigned SRC_HZ       = `RCOD_SRC_HZ,
	parameter int unsigned DRAIN_CYCLES = `RCOD_DRAIN_CYCLES
) (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic [7:0] regAddr,
	input  wire logic       regWrEn,
	input  wire logic [7:0] regWrData,
	output logic      [7:0] regRdData,
	output logic            clkOutPad,
	output logic            clkOutOe,
	output logic            clkOutIe,
	output logic            padSlewLimit,
	output logic            padDriveHigh
);

	localparam logic [7:0] DRAIN_LAST = 8'(DRAIN_CYCLES - 1);

	function automatic logic [9:0] halfTicks(input logic [2:0] div);
		case (div)
			3'h0:    halfTicks = `RCOD_HALF_DIV0;
			3'h1:    halfTicks = `RCOD_HALF_DIV1;
			3'h2:    halfTicks = `RCOD_HALF_DIV2;
			3'h3:    halfTicks = `RCOD_HALF_DIV3;
			3'h4:    halfTicks = `RCOD_HALF_DIV4;
			3'h5:    halfTicks = `RCOD_HALF_DIV5;
			3'h6:    halfTicks = `RCOD_HALF_DIV6;
			default: halfTicks = `RCOD_HALF_DIV7;
		endcase
	endfunction

	rcod_ctrl_s  ctrl_reg;
	rcod_pad_s   pad_reg;
	rcod_state_e state_reg;
	logic [7:0]  regRdData_reg;
	logic        clkOut_reg;
	logic [9:0]  phaseCnt_reg;
	logic [2:0]  activeDiv_reg;
	logic [7:0]  drainCnt_reg;
	logic        tick;
	logic        active;
	logic        stopNow;
	logic        startNow;
	logic        phaseEnd;
	logic        fallNow;
	logic        riseNow;
	logic        drainDone;
	logic        ctrlHit;

	rcod_tick_gen #(
		.MCLK_HZ (MCLK_HZ),
		.TICK_HZ (2 * SRC_HZ)
	) u_tick (
		.mclk  (mclk),
		.rst_n (rst_n),
		.tick  (tick)
	);

	assign ctrlHit = (regAddr == `RCOD_CTRL_OFFSET);

	// control register, plain read/write
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctrl_reg <= rcod_ctrl_s'(`RCOD_CTRL_RESET);
		end else if (regWrEn && ctrlHit) begin
			ctrl_reg <= rcod_ctrl_s'(regWrData);
		end
	end

	// other offsets read as zero
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			regRdData_reg <= 8'h00;
		end else begin
			regRdData_reg <= ctrlHit ? 8'(ctrl_reg) : 8'h00;
		end
	end

	assign active    = (state_reg != RCOD_IDLE);
	assign stopNow   = active && !ctrl_reg.enable && ctrl_reg.extend;
	assign startNow  = (state_reg == RCOD_IDLE) && ctrl_reg.enable && tick;
	assign phaseEnd  = active && tick && (phaseCnt_reg == halfTicks(activeDiv_reg) - 10'd1);
	assign fallNow   = phaseEnd && clkOut_reg && !stopNow;
	assign riseNow   = phaseEnd && !clkOut_reg && !stopNow;
	assign drainDone = (state_reg == RCOD_DRAIN) && fallNow && (drainCnt_reg == DRAIN_LAST);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_reg <= RCOD_IDLE;
		end else begin
			case (state_reg)
				RCOD_IDLE: begin
					if (startNow) begin
						state_reg <= RCOD_RUN;
					end
				end
				RCOD_RUN: begin
					if (stopNow) begin
						state_reg <= RCOD_IDLE;
					end else if (!ctrl_reg.enable) begin
						state_reg <= RCOD_DRAIN;
					end
				end
				RCOD_DRAIN: begin
					if (stopNow) begin
						state_reg <= RCOD_IDLE;
					end else if (ctrl_reg.enable) begin
						state_reg <= RCOD_RUN;
					end else if (drainDone) begin
						state_reg <= RCOD_IDLE;
					end
				end
				default: begin
					state_reg <= RCOD_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			drainCnt_reg <= 8'h00;
		end else if (state_reg != RCOD_DRAIN) begin
			drainCnt_reg <= 8'h00;
		end else if (fallNow) begin
			drainCnt_reg <= drainCnt_reg + 8'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			phaseCnt_reg <= 10'h000;
		end else if (!active || stopNow || phaseEnd) begin
			phaseCnt_reg <= 10'h000;
		end else if (tick) begin
			phaseCnt_reg <= phaseCnt_reg + 10'h001;
		end
	end

	// divide taken only as a high phase begins
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			activeDiv_reg <= 3'h0;
		end else if (startNow || (riseNow && ctrl_reg.enable)) begin
			activeDiv_reg <= ctrl_reg.div;
		end
	end

	// low whenever stopped; a cut high phase is the price of an at-once stop
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			clkOut_reg <= 1'b0;
		end else if (stopNow || fallNow) begin
			clkOut_reg <= 1'b0;
		end else if (startNow || riseNow) begin
			clkOut_reg <= 1'b1;
		end
	end

	// output mode keeps the input buffer off
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pad_reg <= '0;
		end else begin
			pad_reg.clkOut    <= clkOut_reg;
			pad_reg.outEnable <= !ctrl_reg.floatSel;
			pad_reg.inEnable  <= 1'b0;
			pad_reg.slewLimit <= ctrl_reg.slewLimit;
			pad_reg.driveHigh <= ctrl_reg.driveHigh;
		end
	end

	assign regRdData    = regRdData_reg;
	assign clkOutPad    = pad_reg.clkOut;
	assign clkOutOe     = pad_reg.outEnable;
	assign clkOutIe     = pad_reg.inEnable;
	assign padSlewLimit = pad_reg.slewLimit;
	assign padDriveHigh = pad_reg.driveHigh;

	property p_half_len;
		@(posedge mclk) disable iff (!rst_n)
		active |-> (phaseCnt_reg < halfTicks(activeDiv_reg));
	endproperty
	a_half_len: assert property (p_half_len) else $error("phase count past half period");

	property p_fast_toggle;
		@(posedge mclk) disable iff (!rst_n)
		(activeDiv_reg == 3'h0 && state_reg == RCOD_RUN && ctrl_reg.enable && tick && !startNow
			&& $stable(ctrl_reg))
		|=> (clkOut_reg != $past(clkOut_reg));
	endproperty
	a_fast_toggle: assert property (p_fast_toggle) else $error("full rate not toggling per tick");

	property p_slow_half;
		@(posedge mclk) disable iff (!rst_n)
		(activeDiv_reg == 3'h7 && fallNow) |-> (phaseCnt_reg == 10'd975);
	endproperty
	a_slow_half: assert property (p_slow_half) else $error("slowest half period not 976 ticks");

	property p_start;
		@(posedge mclk) disable iff (!rst_n)
		startNow |=> (clkOut_reg && state_reg == RCOD_RUN) ##1 clkOutPad;
	endproperty
	a_start: assert property (p_start) else $error("clock did not start on enable");

	property p_idle_low;
		@(posedge mclk) disable iff (!rst_n)
		(state_reg == RCOD_IDLE) ##1 (state_reg == RCOD_IDLE) |=> !clkOutPad;
	endproperty
	a_idle_low: assert property (p_idle_low) else $error("pad not low while stopped");

	property p_drain_enter;
		@(posedge mclk) disable iff (!rst_n)
		(state_reg == RCOD_RUN && !ctrl_reg.enable && !ctrl_reg.extend) |=> (state_reg == RCOD_DRAIN);
	endproperty
	a_drain_enter: assert property (p_drain_enter) else $error("run-on not entered");

	property p_drain_bound;
		@(posedge mclk) disable iff (!rst_n)
		(state_reg == RCOD_DRAIN) |-> (drainCnt_reg < 8'(DRAIN_CYCLES));
	endproperty
	a_drain_bound: assert property (p_drain_bound) else $error("run-on past its period count");

	property p_stop_now;
		@(posedge mclk) disable iff (!rst_n)
		stopNow |=> (!clkOut_reg && state_reg == RCOD_IDLE) ##1 !clkOutPad;
	endproperty
	a_stop_now: assert property (p_stop_now) else $error("clock not stopped at once");

	property p_float;
		@(posedge mclk) disable iff (!rst_n)
		ctrl_reg.floatSel |=> (!clkOutOe && !clkOutIe);
	endproperty
	a_float: assert property (p_float) else $error("pad buffers on while floating");

	property p_out_mode;
		@(posedge mclk) disable iff (!rst_n)
		!ctrl_reg.floatSel |=> (clkOutOe && !clkOutIe);
	endproperty
	a_out_mode: assert property (p_out_mode) else $error("pad not in output mode");

	property p_slew;
		@(posedge mclk) disable iff (!rst_n)
		1'b1 |=> (padSlewLimit == $past(ctrl_reg.slewLimit));
	endproperty
	a_slew: assert property (p_slew) else $error("slew control does not follow its bit");

	property p_drive;
		@(posedge mclk) disable iff (!rst_n)
		(regWrEn && ctrlHit) |=> ##1 (padDriveHigh == $past(regWrData[`RCOD_BIT_DRIVE], 2));
	endproperty
	a_drive: assert property (p_drive) else $error("drive control does not follow its bit");

	property p_div_at_low;
		@(posedge mclk) disable iff (!rst_n)
		$changed(activeDiv_reg) |-> $rose(clkOut_reg);
	endproperty
	a_div_at_low: assert property (p_div_at_low) else $error("divide changed outside low phase");

	property p_c_start;
		@(posedge mclk) disable iff (!rst_n)
		startNow;
	endproperty
	c_start: cover property (p_c_start);

	property p_c_drain_done;
		@(posedge mclk) disable iff (!rst_n)
		drainDone;
	endproperty
	c_drain_done: cover property (p_c_drain_done);

	property p_c_stop_now;
		@(posedge mclk) disable iff (!rst_n)
		stopNow;
	endproperty
	c_stop_now: cover property (p_c_stop_now);

	property p_c_div_change;
		@(posedge mclk) disable iff (!rst_n)
		riseNow && ctrl_reg.enable && (ctrl_reg.div != activeDiv_reg);
	endproperty
	c_div_change: cover property (p_c_div_change);

endmodule

// ===== sim/rcod_clk_sink.sv
// model of the logic that consumes the clock output pad
`timescale 1ns/1ps
module rcod_clk_sink (
	input  wire logic mclk,
	input  wire logic clkOutPad,
	input  wire logic clkOutOe,
	input  wire logic clrMin,
	output int        riseCount,
	output int        riseCyc,
	output int        minPhase
);
	int   cyc;
	int   phaseLen;
	logic floatPat;
	logic padWire;
	logic wireLast;

	// a released pad floats: show a changing level, never the last driven one
	assign padWire = clkOutOe ? clkOutPad : floatPat;

	initial begin
		cyc = 0;
		phaseLen = 0;
		floatPat = 1'b0;
		wireLast = 1'b0;
		riseCount = 0;
		riseCyc = 0;
		minPhase = 1000000;
	end

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		floatPat <= ~floatPat;
		wireLast <= padWire;
		phaseLen <= phaseLen + 1;
		if (clrMin) begin
			minPhase <= 1000000;
		end
		if (clkOutOe && padWire !== wireLast) begin
			phaseLen <= 1;
			if (!clrMin && phaseLen < minPhase) begin
				minPhase <= phaseLen;
			end
			if (padWire === 1'b1) begin
				riseCount <= riseCount + 1;
				riseCyc <= cyc;
			end
		end
	end
endmodule

// ===== sim/tb_rcod_top.sv
// self-checking bench of the clock output block
`timescale 1ns/1ps
`include "rcod_regs.svh"
module tb_rcod_top
	import rcod_pkg::*;
;
	localparam int DRAIN = 4;
	localparam int LIMIT = 60000;
	localparam int DIVS [8] = '{1, 2, 4, 8, 32, 128, 512, 976};

	logic       mclk;
	logic       rst_n;
	logic [7:0] regAddr;
	logic       regWrEn;
	logic [7:0] regWrData;
	logic [7:0] regRdData;
	logic       clkOutPad;
	logic       clkOutOe;
	logic       clkOutIe;
	logic       padSlewLimit;
	logic       padDriveHigh;
	logic       clrMin;
	int         riseCount;
	int         riseCyc;
	int         minPhase;
	int         errCount = 0;
	int         nChecks = 0;
	int         cycles = 0;

	rcod_top #(.DRAIN_CYCLES(DRAIN)) u_dut (
		.mclk         (mclk),
		.rst_n        (rst_n),
		.regAddr      (regAddr),
		.regWrEn      (regWrEn),
		.regWrData    (regWrData),
		.regRdData    (regRdData),
		.clkOutPad    (clkOutPad),
		.clkOutOe     (clkOutOe),
		.clkOutIe     (clkOutIe),
		.padSlewLimit (padSlewLimit),
		.padDriveHigh (padDriveHigh)
	);

	rcod_clk_sink u_sink (
		.mclk      (mclk),
		.clkOutPad (clkOutPad),
		.clkOutOe  (clkOutOe),
		.clrMin    (clrMin),
		.riseCount (riseCount),
		.riseCyc   (riseCyc),
		.minPhase  (minPhase)
	);

	always #5 mclk = ~mclk;

	task automatic finish_test();
		$display("checks %0d, errors %0d", nChecks, errCount);
		if (errCount == 0 && nChecks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles == LIMIT) begin
			errCount++;
			$display("[ERR] %0t run did not complete", $time);
			finish_test();
		end
	end

	task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
		@(posedge mclk);
		regAddr <= addr;
		regWrEn <= 1'b1;
		regWrData <= data;
		@(posedge mclk);
		regWrEn <= 1'b0;
	endtask

	// read data is registered: sample one edge after the address
	task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
		@(posedge mclk);
		regAddr <= addr;
		@(posedge mclk);
		#1;
		data = regRdData;
	endtask

	task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
		nChecks++;
		if (got !== exp) begin
			errCount++;
			$display("[ERR] %0t value %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic check_span(input int got, input int lo, input int hi);
		nChecks++;
		if (got < lo || got > hi) begin
			errCount++;
			$display("[ERR] %0t count %0d, expected %0d..%0d", $time, got, lo, hi);
		end
	endtask

	// mclk cycles spanned by k output periods, from the next rising edge
	task automatic measure(input int k, output int span);
		int n0;
		int t0;
		n0 = riseCount;
		while (riseCount == n0) @(posedge mclk);
		n0 = riseCount;
		t0 = riseCyc;
		while (riseCount < n0 + k) @(posedge mclk);
		span = riseCyc - t0;
	endtask

	initial begin
		rcod_ctrl_s w;
		logic [7:0] rd;
		int         span;
		int         n0;
		int         prev;
		mclk = 1'b0;
		rst_n = 1'b0;
		regAddr = 8'h00;
		regWrEn = 1'b0;
		regWrData = 8'h00;
		clrMin = 1'b0;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		reg_read(`RCOD_CTRL_OFFSET, rd);
		check_val(rd, 8'h88);
		rd = {4'h0, clkOutOe, clkOutIe, padSlewLimit, padDriveHigh};
		check_val(rd, 8'h08);
		// unmapped place: ignored on write, reads zero
		reg_write(8'h3b, 8'h55);
		reg_read(8'h3b, rd);
		check_val(rd, 8'h00);
		reg_read(`RCOD_CTRL_OFFSET, rd);
		check_val(rd, 8'h88);
		prev = DIVS[0];
		for (int d = 0; d < 8; d++) begin
			w = '0;
			w.extend = 1'b1;
			w.enable = 1'b1;
			w.div = 3'(d);
			w.driveHigh = (d < 2);
			reg_write(`RCOD_CTRL_OFFSET, w);
			clrMin <= 1'b1;
			@(posedge mclk);
			clrMin <= 1'b0;
			measure(1, span);
			measure(4, span);
			check_span(span, DIVS[d] * 25 / 2 - 2, DIVS[d] * 25 / 2 + 2);
			check_span(minPhase, prev * 100 / 64 - 1, 1000000);
			prev = DIVS[d];
			reg_read(`RCOD_CTRL_OFFSET, rd);
			check_val(rd, w);
		end
		w = '0;
		w.extend = 1'b1;
		w.enable = 1'b1;
		w.driveHigh = 1'b1;
		reg_write(`RCOD_CTRL_OFFSET, w);
		measure(1, span);
		w.enable = 1'b0;
		reg_write(`RCOD_CTRL_OFFSET, w);
		repeat (3) @(posedge mclk);
		#1;
		check_val({7'h0, clkOutPad}, 8'h00);
		n0 = riseCount;
		repeat (50) @(posedge mclk);
		check_span(riseCount - n0, 0, 0);
		for (int i = 0; i < 8; i++) begin
			w = '0;
			w.extend = 1'b1;
			{w.floatSel, w.slewLimit, w.driveHigh} = 3'(i);
			reg_write(`RCOD_CTRL_OFFSET, w);
			repeat (2) @(posedge mclk);
			#1;
			rd = {4'h0, clkOutOe, clkOutIe, padSlewLimit, padDriveHigh};
			check_val(rd, {4'h0, ~w.floatSel, 1'b0, w.slewLimit, w.driveHigh});
		end
		w = '0;
		w.enable = 1'b1;
		w.driveHigh = 1'b1;
		w.div = 3'h1;
		reg_write(`RCOD_CTRL_OFFSET, w);
		measure(1, span);
		w.enable = 1'b0;
		reg_write(`RCOD_CTRL_OFFSET, w);
		n0 = riseCount;
		repeat (DRAIN * 8 + 40) @(posedge mclk);
		#1;
		check_span(riseCount - n0, DRAIN, DRAIN + 1);
		check_val({7'h0, clkOutPad}, 8'h00);
		// enable set again during run-on keeps the clock going
		w.enable = 1'b1;
		reg_write(`RCOD_CTRL_OFFSET, w);
		measure(1, span);
		w.enable = 1'b0;
		reg_write(`RCOD_CTRL_OFFSET, w);
		w.enable = 1'b1;
		reg_write(`RCOD_CTRL_OFFSET, w);
		n0 = riseCount;
		repeat (DRAIN * 8 + 40) @(posedge mclk);
		check_span(riseCount - n0, 10, 13);
		// extend set in mid run-on cuts it short
		w.enable = 1'b0;
		reg_write(`RCOD_CTRL_OFFSET, w);
		w.extend = 1'b1;
		reg_write(`RCOD_CTRL_OFFSET, w);
		repeat (3) @(posedge mclk);
		#1;
		check_val({7'h0, clkOutPad}, 8'h00);
		n0 = riseCount;
		repeat (50) @(posedge mclk);
		check_span(riseCount - n0, 0, 0);
		finish_test();
	end
endmodule
